// ### rtl/fsd_pkg.sv
package fsd_pkg;
   // register byte offsets
   localparam logic [3:0] FUSE_CTRL_OFFS = 4'h0;
   localparam logic [3:0] FUSE_STAT_OFFS = 4'h4;
   // field positions of the feature fuse control word
   localparam int PCI_BIT = 0;
   localparam int SERIAL_PAIR_BIT = 1;
   localparam int UTOPIA_BIT = 2;
   localparam int MAC_BIT0 = 3;
   localparam int NUM_ENGINES = 3;
   localparam int SMII_BIT = 6;
   localparam int USB_HOST_BIT = 7;
   localparam int USB_DEV_BIT = 8;
   localparam int ECC_BIT = 9;
   localparam int NUM_FEAT = 10;
   // a set bit disables the feature, bit 6 selects smii over mii; reset enables all but the engine 0 mac and smii, utopia wins
   localparam logic [NUM_FEAT-1:0] FUSE_RESET_VAL = 10'h008;
   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic pci;
      logic serial_port_pair;
      logic utopia;
      logic [NUM_ENGINES-1:0] engine_mac;
      logic mii;
      logic smii;
      logic usb_host;
      logic usb_dev;
      logic ecc;
   } fsd_enables_t;
endpackage

// ### rtl/fsd_feature_fuse.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - software writes the fuse word; a disabled module is isolated from the processor
// - one bit enables or disables the whole pci bus together
// - one shared bit disables both serial ports, never just one
// - utopia and first packet engine macs exclude each other; enabling one disables other
// - only one of mii or smii mac types is ever enabled
// - each packet engine has its own mac enable bit; only engines 1 and 2 are independent, engine 0 is paired against utopia
// - usb host and usb device each have an independent enable bit
// - ecc has its own disable bit apart from the memory interface
module fsd_feature_fuse (
   input wire logic CLOCK_IN,
   input wire logic RESET_N_IN,
   input wire logic CLK_EN_IN,
   input wire logic [3:0] AWADDR_IN,
   input wire logic AWVALID_IN,
   output logic AWREADY_OUT,
   input wire logic [31:0] WDATA_IN,
   input wire logic [3:0] WSTRB_IN,
   input wire logic WVALID_IN,
   output logic WREADY_OUT,
   output logic [1:0] BRESP_OUT,
   output logic BVALID_OUT,
   input wire logic BREADY_IN,
   input wire logic [3:0] ARADDR_IN,
   input wire logic ARVALID_IN,
   output logic ARREADY_OUT,
   output logic [31:0] RDATA_OUT,
   output logic [1:0] RRESP_OUT,
   output logic RVALID_OUT,
   input wire logic RREADY_IN,
   output fsd_pkg::fsd_enables_t FEATURE_EN_OUT
);
   logic [fsd_pkg::NUM_FEAT-1:0] fuse_ff;
   logic [fsd_pkg::NUM_FEAT-1:0] nxt_fuse;
   logic aw_got_ff;
   logic w_got_ff;
   logic [3:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic utopia_was_ff;
   logic mac_a_was_ff;
   fsd_pkg::fsd_enables_t nxt_en;
   logic do_write;
   logic [fsd_pkg::NUM_FEAT-1:0] wr_bits;
   logic [fsd_pkg::NUM_ENGINES-1:0] mac_en;

   // address and data are taken in either order, one write at a time
   assign AWREADY_OUT = CLK_EN_IN && !aw_got_ff && !BVALID_OUT;
   assign WREADY_OUT = CLK_EN_IN && !w_got_ff && !BVALID_OUT;
   assign do_write = CLK_EN_IN && aw_got_ff && w_got_ff && !BVALID_OUT;
   assign ARREADY_OUT = CLK_EN_IN && !RVALID_OUT;

   // capture write address and data channels
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= 4'h0;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else if (CLK_EN_IN) begin
         if (AWVALID_IN && AWREADY_OUT) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= AWADDR_IN;
         end else if (do_write) begin
            aw_got_ff <= 1'b0;
         end
         if (WVALID_IN && WREADY_OUT) begin
            w_got_ff <= 1'b1;
            wdata_ff <= WDATA_IN;
            wstrb_ff <= WSTRB_IN;
         end else if (do_write) begin
            w_got_ff <= 1'b0;
         end
      end
   end

   // merge byte lanes of the written word
   always_comb begin
      wr_bits = fuse_ff;
      if (wstrb_ff[0]) wr_bits[7:0] = wdata_ff[7:0];
      if (wstrb_ff[1]) wr_bits[fsd_pkg::NUM_FEAT-1:8] = wdata_ff[fsd_pkg::NUM_FEAT-1:8];
   end

   // resolve exclusions: a newly enabled side of a pair wins over the other
   always_comb begin
      nxt_fuse = wr_bits;
      if (!wr_bits[fsd_pkg::UTOPIA_BIT] && !wr_bits[fsd_pkg::MAC_BIT0]) begin
         if (utopia_was_ff) nxt_fuse[fsd_pkg::UTOPIA_BIT] = 1'b1;
         else if (mac_a_was_ff) nxt_fuse[fsd_pkg::MAC_BIT0] = 1'b1;
         else nxt_fuse[fsd_pkg::MAC_BIT0] = 1'b1;
      end
   end

   // fuse word is written by software and held until the next write or reset
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         fuse_ff <= fsd_pkg::FUSE_RESET_VAL;
      end else if (CLK_EN_IN && do_write && awaddr_ff == fsd_pkg::FUSE_CTRL_OFFS) begin
         fuse_ff <= nxt_fuse;
      end
   end

   // remember which side of the utopia pair was enabled before
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         utopia_was_ff <= 1'b1;
         mac_a_was_ff <= 1'b0;
      end else if (CLK_EN_IN) begin
         utopia_was_ff <= !fuse_ff[fsd_pkg::UTOPIA_BIT];
         mac_a_was_ff <= !fuse_ff[fsd_pkg::MAC_BIT0];
      end
   end

   // write response
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         BVALID_OUT <= 1'b0;
         BRESP_OUT <= fsd_pkg::RESP_OKAY;
      end else if (CLK_EN_IN) begin
         if (do_write) begin
            BVALID_OUT <= 1'b1;
            BRESP_OUT <= (awaddr_ff == fsd_pkg::FUSE_CTRL_OFFS) ? fsd_pkg::RESP_OKAY : fsd_pkg::RESP_SLVERR;
         end else if (BREADY_IN) begin
            BVALID_OUT <= 1'b0;
         end
      end
   end

   // read channel: control word or resolved enables
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         RVALID_OUT <= 1'b0;
         RDATA_OUT <= 32'h0000_0000;
         RRESP_OUT <= fsd_pkg::RESP_OKAY;
      end else if (CLK_EN_IN) begin
         if (ARVALID_IN && ARREADY_OUT) begin
            RVALID_OUT <= 1'b1;
            RRESP_OUT <= fsd_pkg::RESP_OKAY;
            if (ARADDR_IN == fsd_pkg::FUSE_CTRL_OFFS) begin
               RDATA_OUT <= {22'h000000, fuse_ff};
            end else if (ARADDR_IN == fsd_pkg::FUSE_STAT_OFFS) begin
               RDATA_OUT <= {21'h000000, nxt_en};
            end else begin
               RDATA_OUT <= 32'h0000_0000;
               RRESP_OUT <= fsd_pkg::RESP_SLVERR;
            end
         end else if (RREADY_IN) begin
            RVALID_OUT <= 1'b0;
         end
      end
   end

   // decode enables from the fuse word
   always_comb begin
      nxt_en.pci = !fuse_ff[fsd_pkg::PCI_BIT];
      nxt_en.serial_port_pair = !fuse_ff[fsd_pkg::SERIAL_PAIR_BIT];
      nxt_en.utopia = !fuse_ff[fsd_pkg::UTOPIA_BIT] && fuse_ff[fsd_pkg::MAC_BIT0];
      nxt_en.engine_mac = mac_en;
      nxt_en.mii = !fuse_ff[fsd_pkg::SMII_BIT];
      nxt_en.smii = fuse_ff[fsd_pkg::SMII_BIT];
      nxt_en.usb_host = !fuse_ff[fsd_pkg::USB_HOST_BIT];
      nxt_en.usb_dev = !fuse_ff[fsd_pkg::USB_DEV_BIT];
      nxt_en.ecc = !fuse_ff[fsd_pkg::ECC_BIT];
   end

   // one mac enable per packet engine
   genvar g;
   generate
      for (g = 0; g < fsd_pkg::NUM_ENGINES; g++) begin : g_mac
         assign mac_en[g] = !fuse_ff[fsd_pkg::MAC_BIT0 + g];
      end
   endgenerate

   // enables leave from flip-flops
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         FEATURE_EN_OUT <= '0;
      end else if (CLK_EN_IN) begin
         FEATURE_EN_OUT <= nxt_en;
      end
   end

   property p_excl;
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN) !(FEATURE_EN_OUT.utopia && FEATURE_EN_OUT.engine_mac[0]);
   endproperty
   a_excl: assert property (p_excl) else $error("utopia and engine mac both on");
   property p_mii;
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN) !(FEATURE_EN_OUT.mii && FEATURE_EN_OUT.smii);
   endproperty
   a_mii: assert property (p_mii) else $error("mii and smii both on");
   property p_hold;
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN) !do_write |=> $stable(fuse_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("fuse word changed without write");
   property p_pci;
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN) CLK_EN_IN |=> FEATURE_EN_OUT.pci == !$past(fuse_ff[fsd_pkg::PCI_BIT]);
   endproperty
   a_pci: assert property (p_pci) else $error("pci enable mismatch");
   property p_wr;
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN) do_write |=> BVALID_OUT;
   endproperty
   a_wr: assert property (p_wr) else $error("no write response");
   property p_usb;
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN) CLK_EN_IN |=> FEATURE_EN_OUT.usb_dev == !$past(fuse_ff[fsd_pkg::USB_DEV_BIT]);
   endproperty
   a_usb: assert property (p_usb) else $error("usb device enable mismatch");
   property p_ecc;
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN) CLK_EN_IN |=> FEATURE_EN_OUT.ecc == !$past(fuse_ff[fsd_pkg::ECC_BIT]);
   endproperty
   a_ecc: assert property (p_ecc) else $error("ecc enable mismatch");
   property p_ser;
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
         CLK_EN_IN |=> FEATURE_EN_OUT.serial_port_pair == !$past(fuse_ff[fsd_pkg::SERIAL_PAIR_BIT]);
   endproperty
   a_ser: assert property (p_ser) else $error("serial pair enable mismatch");
   property p_mac1;
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
         CLK_EN_IN |=> FEATURE_EN_OUT.engine_mac[1] == !$past(fuse_ff[fsd_pkg::MAC_BIT0 + 1]);
   endproperty
   a_mac1: assert property (p_mac1) else $error("engine mac enable mismatch");
   c_write: cover property (@(posedge CLOCK_IN) do_write);
   c_read: cover property (@(posedge CLOCK_IN) RVALID_OUT && RREADY_IN);
   c_smii: cover property (@(posedge CLOCK_IN) FEATURE_EN_OUT.smii);
endmodule
`default_nettype wire

// ### sim/fsd_feature_fuse_test.sv
`timescale 1ns/10ps
`default_nettype none
module fsd_feature_fuse_test;
   logic clk = 1'b0;
   logic rst_n;
   logic clk_en = 1'b1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   fsd_pkg::fsd_enables_t feat;
   logic [9:0] ctrl = fsd_pkg::FUSE_RESET_VAL;
   logic [31:0] seed = 32'h0000e428;
   int miscompares = 0;
   int compares = 0;
   // free-running bench clock
   always #4 clk = ~clk;
   fsd_feature_fuse fsd_feature_fuse_i (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(clk_en),
      .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata),
      .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp),
      .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
      .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
      .RREADY_IN(rready), .FEATURE_EN_OUT(feat));
   // xorshift source, fixed start
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // expected stored word after a write, with utopia and mac0 kept apart
   function automatic logic [9:0] nxt(logic [9:0] o, logic [31:0] d, logic [3:0] s);
      logic [9:0] n;
      n = o;
      if (s[0]) n[7:0] = d[7:0];
      if (s[1]) n[9:8] = d[9:8];
      if (!n[2] && !n[3]) begin
         if (o[2]) n[3] = 1'b1;
         else if (o[3]) n[2] = 1'b1;
         else n[3] = 1'b1;
      end
      return n;
   endfunction
   // expected enables, a set control bit disables, bit 6 selects smii over mii
   function automatic fsd_pkg::fsd_enables_t en(logic [9:0] c);
      fsd_pkg::fsd_enables_t e;
      e = {~c[0], ~c[1], ~c[2], ~c[5:3], ~c[6], c[6], ~c[7], ~c[8], ~c[9]};
      return e;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one axi write, payload held until each ready
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      int n;
      n = 0;
      r = 2'h3;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (n == 0) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            n = 1;
         end
      end
      bready <= 1'b0;
      @(posedge clk);
   endtask
   // one axi read
   task automatic rd(input logic [3:0] a, output logic [31:0] q, output logic [1:0] r);
      int n;
      n = 0;
      q = 'x;
      r = 2'h3;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (n == 0) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            q = rdata;
            r = rresp;
            n = 1;
         end
      end
      rready <= 1'b0;
      @(posedge clk);
   endtask
   // write the control word, then check outputs and both read-backs
   task automatic wctl(input logic [31:0] d, input logic [3:0] s);
      logic [1:0] r;
      logic [31:0] q;
      wr(fsd_pkg::FUSE_CTRL_OFFS, d, s, r);
      ctrl = nxt(ctrl, d, s);
      chk({30'h0, r}, {30'h0, fsd_pkg::RESP_OKAY});
      @(posedge clk);
      chk({21'h0, feat}, {21'h0, en(ctrl)});
      rd(fsd_pkg::FUSE_CTRL_OFFS, q, r);
      chk(q, {22'h0, ctrl});
      chk({30'h0, r}, {30'h0, fsd_pkg::RESP_OKAY});
      rd(fsd_pkg::FUSE_STAT_OFFS, q, r);
      chk(q, {21'h0, en(ctrl)});
      chk({30'h0, r}, {30'h0, fsd_pkg::RESP_OKAY});
   endtask
   task automatic summarize();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      repeat (8000) @(posedge clk);
      miscompares++;
      summarize();
   end
   // main sequence
   initial begin
      logic [1:0] r;
      logic [31:0] q, d;
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk({21'h0, feat}, 32'h0);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk({21'h0, feat}, {21'h0, en(fsd_pkg::FUSE_RESET_VAL)});
      for (int i = 0; i < 10; i++) begin
         wctl(32'h1 << i, 4'h3);
      end
      wctl(32'h004, 4'h1);
      wctl(32'h000, 4'h1);
      wctl(32'h000, 4'h1);
      wctl(32'h3ff, 4'h2);
      wctl(32'hffff_fcff, 4'hc);
      wctl(32'h3ff, 4'h3);
      $display("test corners done");
      wr(4'h8, 32'h000, 4'hf, r);
      chk({30'h0, r}, {30'h0, fsd_pkg::RESP_SLVERR});
      rd(4'hc, q, r);
      chk(q, 32'h0);
      chk({30'h0, r}, {30'h0, fsd_pkg::RESP_SLVERR});
      chk({21'h0, feat}, {21'h0, en(ctrl)});
      clk_en <= 1'b0;
      repeat (3) @(posedge clk);
      chk({30'h0, awready, arready}, 32'h0);
      clk_en <= 1'b1;
      @(posedge clk);
      $display("test unmapped done");
      for (int k = 0; k < 40; k++) begin
         d = rnd();
         q = rnd();
         if (ctrl[2] && ctrl[3]) d[3] = 1'b1;
         wctl(d, q[3:0]);
      end
      $display("test random done");
      rst_n <= 1'b0;
      @(posedge clk);
      chk({21'h0, feat}, 32'h0);
      rst_n <= 1'b1;
      ctrl = fsd_pkg::FUSE_RESET_VAL;
      repeat (2) @(posedge clk);
      chk({21'h0, feat}, {21'h0, en(ctrl)});
      $display("test reset done");
      summarize();
   end
endmodule
`default_nettype wire
